// file: reset_cause_and_poweron_clear.sv
// reset merge, reset cause flags and power-on-clear threshold logic
`timescale 1ns/100ps
module reset_cause_and_poweron_clear (
  input  wire logic        ref_clk,                  // system clock, 25 MHz
  input  wire logic        rst,                      // synchronous block reset
  input  wire logic        ext_reset_n,              // external reset pin, low active
  input  wire logic        wdog_reset_req,           // watchdog overflow request
  input  wire logic        lowvolt_reset_req,        // lowvolt detector reset request
  input  wire logic        supply_above_low,         // comparator: supply above low threshold
  input  wire logic        supply_above_high,        // comparator: supply above high threshold
  input  wire logic        poweron_threshold_select, // option bit: threshold mode
  input  wire logic        wdog_option_bit,          // option bit: watchdog enable reset value
  input  wire logic [15:0] bus_addr,                 // core address
  input  wire logic        bus_rd,                   // core read strobe
  input  wire logic        bus_bit_access,           // core single-bit access marker
  output logic      [7:0]  bus_rdata,                // read data
  output logic             sys_reset,                // reset to general hardware
  output logic             lowvolt_reset,            // reset to lowvolt regs and detector
  output logic             wdog_unit_reset,          // reset to watchdog unit
  output logic             pc_undefined,             // program counter not valid
  output logic      [15:0] reset_vector,             // fetch address after release
  output logic             use_internal_osc,         // run on internal oscillator
  output logic      [7:0]  watchdog_enable_reg,      // watchdog enable reset value
  output logic      [7:0]  cal_hour_rst,             // hour and alarm_hour_reg reset value
  output logic      [7:0]  cal_daymon_rst,           // day and month reset value
  output logic      [7:0]  cal_other_rst,            // other counter reset value
  output logic      [7:0]  irq_flag_rst,             // request flag reset value
  output logic      [7:0]  irq_mask_rst              // mask and priority reset value
);
  logic             ext_low_s;      // synchronised external reset active
  logic             above_low_s;
  logic             above_high_s;
  logic             wdog_s;
  logic             lowv_s;
  rst_seq_pkg::poc_state_t poc_ff, nxt_poc;
  logic             wdog_cause_ff;
  logic             lowv_cause_ff;
  logic             ext_async;
  logic             poc_async;

  // async assertion of the pin and comparator drop, sync release
  assign ext_async = ~ext_reset_n;
  assign poc_async = ~supply_above_low;

  level_sync #(.INIT(1'b1)) u_sync_ext (
    .ref_clk (ref_clk),
    .arst    (ext_async),
    .d       (1'b0),
    .q       (ext_low_s)
  );
  level_sync #(.INIT(1'b0)) u_sync_low (
    .ref_clk (ref_clk),
    .arst    (poc_async),
    .d       (1'b1),
    .q       (above_low_s)
  );
  level_sync #(.INIT(1'b0)) u_sync_high (
    .ref_clk (ref_clk),
    .arst    (1'b0),
    .d       (supply_above_high),
    .q       (above_high_s)
  );
  level_sync #(.INIT(1'b0)) u_sync_wdog (
    .ref_clk (ref_clk),
    .arst    (1'b0),
    .d       (wdog_reset_req),
    .q       (wdog_s)
  );
  level_sync #(.INIT(1'b0)) u_sync_lowv (
    .ref_clk (ref_clk),
    .arst    (1'b0),
    .d       (lowvolt_reset_req),
    .q       (lowv_s)
  );

  // power-on-clear state: dip below low threshold always returns to active
  always_comb begin
    nxt_poc = poc_ff;
    case (poc_ff)
      rst_seq_pkg::POC_ACTIVE: begin
        if (above_low_s) begin
          nxt_poc = poc_threshold_select_hi() ? rst_seq_pkg::POC_WAIT_HIGH
                                             : rst_seq_pkg::POC_RELEASED;
        end
      end
      rst_seq_pkg::POC_WAIT_HIGH: begin
        if (!above_low_s) nxt_poc = rst_seq_pkg::POC_ACTIVE;
        else if (above_high_s) nxt_poc = rst_seq_pkg::POC_RELEASED;
      end
      default: begin
        if (!above_low_s) nxt_poc = rst_seq_pkg::POC_ACTIVE;
      end
    endcase
  end

  function automatic logic poc_threshold_select_hi();
    return poweron_threshold_select;
  endfunction : poc_threshold_select_hi

  // rst models power application
  always_ff @(posedge ref_clk) begin
    if (rst) poc_ff <= rst_seq_pkg::POC_ACTIVE;
    else     poc_ff <= nxt_poc;
  end

  // reset source decode
  wire poc_reset    = (poc_ff != rst_seq_pkg::POC_RELEASED) | poc_async | rst;
  wire clear_reset  = poc_reset | ext_low_s | ext_async;
  wire cause_read   = bus_rd & (bus_addr == rst_seq_pkg::CAUSE_ADDR);
  wire clear_causes = clear_reset | cause_read;

  // cause flags: clear beats set, each source touches only its bit
  always_ff @(posedge ref_clk) begin
    if (clear_causes) begin
      wdog_cause_ff <= rst_seq_pkg::CAUSE_RST_VAL[rst_seq_pkg::WDOG_BIT_POS];
      lowv_cause_ff <= rst_seq_pkg::CAUSE_RST_VAL[rst_seq_pkg::LOWV_BIT_POS];
    end else begin
      if (wdog_s) wdog_cause_ff <= 1'b1;
      if (lowv_s) lowv_cause_ff <= 1'b1;
    end
  end

  // read data: whole byte, other bits zero; writes have no path here
  wire [7:0] cause_byte = {3'h0, wdog_cause_ff, 3'h0, lowv_cause_ff};
  always_ff @(posedge ref_clk) begin
    if (rst) bus_rdata <= 8'h00;
    else     bus_rdata <= cause_read ? cause_byte : 8'h00;
  end

  // reset fan-out
  assign sys_reset        = clear_reset | wdog_s | lowv_s;
  assign lowvolt_reset    = clear_reset | wdog_s;
  assign wdog_unit_reset  = sys_reset;
  assign pc_undefined     = sys_reset;
  assign reset_vector     = rst_seq_pkg::RESET_VECTOR;
  assign use_internal_osc = 1'b1;

  // reset values of peripheral registers
  assign watchdog_enable_reg = wdog_option_bit ? rst_seq_pkg::WDOG_EN_VAL_HI
                                               : rst_seq_pkg::WDOG_EN_VAL_LO;
  assign cal_hour_rst   = rst_seq_pkg::HOUR_RST_VAL;
  assign cal_daymon_rst = rst_seq_pkg::DAY_RST_VAL;
  assign cal_other_rst  = rst_seq_pkg::ZERO_RST_VAL;
  assign irq_flag_rst   = rst_seq_pkg::IRQ_FLAG_RST_VAL;
  assign irq_mask_rst   = rst_seq_pkg::IRQ_MASK_RST_VAL;

  // checks
  a_read_clears: assert property (@(posedge ref_clk) disable iff (rst)
    cause_read |=> (cause_byte == 8'h00 || $past(wdog_s) || $past(lowv_s))
      || !$past(cause_read) ) else $error("cause read did not clear");
  a_ext_clears: assert property (@(posedge ref_clk) disable iff (rst)
    ext_low_s |=> cause_byte == 8'h00) else $error("external reset kept cause");
  a_wdog_sets: assert property (@(posedge ref_clk) disable iff (rst)
    (wdog_s && !clear_causes) |=> wdog_cause_ff) else $error("watchdog bit not set");
  a_lowv_keeps_wd: assert property (@(posedge ref_clk) disable iff (rst)
    (lowv_s && !wdog_s && !clear_causes) |=> wdog_cause_ff == $past(wdog_cause_ff))
    else $error("lowvolt reset changed watchdog bit");
  a_zero_bits: assert property (@(posedge ref_clk) disable iff (rst)
    (bus_rdata & 8'hEE) == 8'h00) else $error("reserved cause bits set");
  a_lowv_spared: assert property (@(posedge ref_clk) disable iff (rst)
    (lowv_s && !wdog_s && !clear_reset) |-> !lowvolt_reset)
    else $error("lowvolt reset hit lowvolt regs");
  a_poc_low_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !above_low_s |-> sys_reset) else $error("reset released below threshold");
  a_high_mode: assert property (@(posedge ref_clk) disable iff (rst)
    (poweron_threshold_select && $past(poc_ff) == rst_seq_pkg::POC_ACTIVE
     && poc_ff != rst_seq_pkg::POC_ACTIVE) |-> poc_ff == rst_seq_pkg::POC_WAIT_HIGH)
    else $error("high mode skipped high threshold");
  c_poc_release: cover property (@(posedge ref_clk) poc_ff == rst_seq_pkg::POC_RELEASED);
  c_wdog_flag: cover property (@(posedge ref_clk) wdog_cause_ff);
  c_lowv_flag: cover property (@(posedge ref_clk) lowv_cause_ff && wdog_cause_ff);
endmodule : reset_cause_and_poweron_clear

// file: rst_seq_pkg.sv
// constants for the reset cause and power-on-clear sequencer
package rst_seq_pkg;
  localparam logic [15:0] CAUSE_ADDR       = 16'hFFAC;
  localparam int          WDOG_BIT_POS     = 4;
  localparam int          LOWV_BIT_POS     = 0;
  localparam logic [7:0]  CAUSE_RST_VAL    = 8'h00;
  localparam logic [7:0]  LOWV_REG_RST_VAL = 8'h00;
  localparam logic [7:0]  HOUR_RST_VAL     = 8'h12;
  localparam logic [7:0]  DAY_RST_VAL      = 8'h01;
  localparam logic [7:0]  ZERO_RST_VAL     = 8'h00;
  localparam logic [7:0]  IRQ_FLAG_RST_VAL = 8'h00;
  localparam logic [7:0]  IRQ_MASK_RST_VAL = 8'hFF;
  localparam logic [7:0]  WDOG_EN_VAL_LO   = 8'h1A;
  localparam logic [7:0]  WDOG_EN_VAL_HI   = 8'h9A;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;
  localparam int          SYNC_STAGES      = 2;
  typedef enum logic [1:0] {POC_ACTIVE, POC_WAIT_HIGH, POC_RELEASED} poc_state_t;
endpackage : rst_seq_pkg

// file: level_sync.sv
// two-stage synchroniser for an asynchronous level, with async preset
`timescale 1ns/100ps
module level_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic ref_clk,   // system clock
  input  wire logic arst,      // async preset to INIT
  input  wire logic d,         // asynchronous level
  output logic      q          // synchronised level
);
  logic meta_ff;
  // first stage is read only by the second stage
  always_ff @(posedge ref_clk or posedge arst) begin
    if (arst) begin
      meta_ff <= INIT;
      q       <= INIT;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule : level_sync

// file: core_model.sv
// processor core model that reads the cause register bytewise
`timescale 1ns/100ps
module core_model (
  input  wire logic        ref_clk,        // system clock
  input  wire logic [7:0]  bus_rdata,      // read data
  output logic      [15:0] bus_addr,       // core address
  output logic             bus_rd,         // read strobe
  output logic             bus_bit_access  // single-bit marker
);
  // idle bus at time zero, bit access never used
  initial begin
    bus_addr = 16'h0000;
    bus_rd = 1'b0;
    bus_bit_access = 1'b0;
  end
  // strobe spans one rising edge, data is taken in the following cycle
  task automatic rd_byte(input logic [15:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge ref_clk);
    d = bus_rdata;
    bus_rd = 1'b0;
    bus_addr = ~a; // released address no longer shows the old value
  endtask : rd_byte
endmodule : core_model

// file: reset_cause_and_poweron_clear_tb_top.sv
// testbench for the reset cause and power-on-clear sequencer
`timescale 1ns/100ps
module reset_cause_and_poweron_clear_tb_top;
  logic        ref_clk = 1'b0;
  logic        rst, ext_reset_n, wdog_reset_req, lowvolt_reset_req;
  logic        supply_above_low, supply_above_high, poweron_threshold_select;
  logic        wdog_option_bit, bus_rd, bus_bit_access;
  logic        sys_reset, lowvolt_reset, wdog_unit_reset, pc_undefined, use_internal_osc;
  logic [15:0] bus_addr, reset_vector;
  logic [7:0]  bus_rdata, watchdog_enable_reg, cal_hour_rst, cal_daymon_rst;
  logic [7:0]  cal_other_rst, irq_flag_rst, irq_mask_rst, exp_flags, got;
  logic [31:0] seed;
  int          n_errors, n_compared, ev;
  int          corner [10] = '{0, 1, 4, 1, 0, 4, 2, 4, 3, 4};
  // clock at 25 MHz
  always #20 ref_clk = ~ref_clk;
  reset_cause_and_poweron_clear u_dut (.ref_clk, .rst, .ext_reset_n, .wdog_reset_req,
    .lowvolt_reset_req, .supply_above_low, .supply_above_high, .poweron_threshold_select,
    .wdog_option_bit, .bus_addr, .bus_rd, .bus_bit_access, .bus_rdata, .sys_reset,
    .lowvolt_reset, .wdog_unit_reset, .pc_undefined, .reset_vector, .use_internal_osc,
    .watchdog_enable_reg, .cal_hour_rst, .cal_daymon_rst, .cal_other_rst,
    .irq_flag_rst, .irq_mask_rst);
  core_model u_core (.ref_clk, .bus_rdata, .bus_addr, .bus_rd, .bus_bit_access);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // expected flags: watchdog sets bit 4, lowvolt bit 0, external and poweron clear
  function automatic logic [7:0] cause_after(input logic [7:0] f, input int e);
    case (e)
      0: return f | 8'h10;
      1: return f | 8'h01;
      2, 3: return 8'h00;
      default: return f;
    endcase
  endfunction : cause_after
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wait_rel();
    for (int i = 0; i < 30 && sys_reset !== 1'b0; i++) @(negedge ref_clk);
    chk(sys_reset, 16'h0000);
  endtask : wait_rel
  task automatic conclude();
    $display("counts: compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // hang guard, well beyond the expected run length
  initial begin
    #400000;
    n_errors++;
    conclude();
  end
  // power-up in both threshold modes, then mixed reset sources and reads
  initial begin
    {rst, ext_reset_n, wdog_reset_req, lowvolt_reset_req} = 4'b1100;
    {supply_above_low, supply_above_high, poweron_threshold_select, wdog_option_bit} = 4'h0;
    seed = 32'd99042;
    exp_flags = 8'h00;
    repeat (6) @(negedge ref_clk);
    chk({sys_reset, pc_undefined}, 16'h0003);
    chk(bus_rdata, 16'h0000);
    chk(reset_vector, 16'h0000);
    chk({cal_hour_rst, cal_daymon_rst}, 16'h1201);
    chk({cal_other_rst, irq_flag_rst}, 16'h0000);
    chk({irq_mask_rst, 7'h00, use_internal_osc}, 16'hFF01);
    rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk(sys_reset, 16'h0001);
    supply_above_low = 1'b1;
    wait_rel();
    $display("test poweron low threshold done");
    {rst, supply_above_low, poweron_threshold_select} = 3'b101;
    @(negedge ref_clk);
    {rst, supply_above_low} = 2'b01;
    repeat (10) @(negedge ref_clk);
    chk(sys_reset, 16'h0001);
    supply_above_high = 1'b1;
    wait_rel();
    $display("test poweron high threshold done");
    for (int k = 0; k < 40; k++) begin
      ev = (k < 10) ? corner[k] : int'(xs() % 5);
      wdog_option_bit = xs() & 1;
      @(negedge ref_clk);
      chk(watchdog_enable_reg, wdog_option_bit ? 8'h9A : 8'h1A);
      if (ev == 4) begin
        u_core.rd_byte(16'hFFAC, got);
        chk(got, exp_flags);
        u_core.rd_byte(16'hFFAC, got);
        chk(got, 16'h0000);
        u_core.rd_byte(16'hFF00 | (xs() & 8'hAB), got);
        chk(got, 16'h0000);
        exp_flags = 8'h00;
      end else begin
        wdog_reset_req = (ev == 0);
        lowvolt_reset_req = (ev == 1);
        ext_reset_n = (ev != 2);
        supply_above_low = (ev != 3);
        supply_above_high = (ev != 3);
        repeat (4) @(negedge ref_clk);
        chk(sys_reset, 16'h0001);
        chk(lowvolt_reset, ev != 1);
        if (ev == 0) chk(wdog_unit_reset, 16'h0001);
        {wdog_reset_req, lowvolt_reset_req, ext_reset_n, supply_above_low} = 4'b0011;
        if (ev == 3) begin
          repeat (8) @(negedge ref_clk);
          chk(sys_reset, 16'h0001);
          supply_above_high = 1'b1;
        end
        wait_rel();
        exp_flags = cause_after(exp_flags, ev);
      end
      $display("test event %0d kind %0d done", k, ev);
    end
    conclude();
  end
endmodule : reset_cause_and_poweron_clear_tb_top
